// File: src/cam_host_bus_interface.sv
// Host-side parallel bus port of the search memory: select, strobes, stall and tri-state control
// Operation
// RQ1: The host keeps the clock at or below 33 MHz, or 50 MHz in registered-output mode.
// RQ2: A low stall input sampled on an edge stalls the port for exactly one cycle from the next edge; the code starts it two edges later.
// RQ3: While stalled every output holds the value it had just before the stall.
// RQ4: Select and match-output-enable still control the output enables during a stall.
// RQ5: The port is selected only when both chip-select inputs are active together.
// RQ6: When unselected, word bus, match index, multi-match error and cascade mask are high impedance.
// RQ7: The port takes a 13-bit address picking a memory entry or a register.
// RQ8: In register space address bits 12 down to 8 are ignored.
// RQ9: Words are 64 bits on one two-way bus shared by memory and registers.
// RQ10: While the write strobe is active the port never drives the word bus.
// RQ11: The port drives read data only while the read output enable is active.
// RQ12: Space select high targets the memory array, low the register space.
// RQ13: Match-output-enable high floats match index and error, low lets them drive.
// RQ14: The host presents address, space and write data with the write strobe on a selected edge.
`timescale 1ns/1ps
module cam_host_bus_interface (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic stall_n,
  input wire logic chip_sel_n,
  input wire logic chip_sel_b_n,
  input wire logic [cam_host_pkg::ADDR_W-1:0] addr_bus,
  input wire logic space_mem,
  input wire logic write_n,
  input wire logic read_oe_n,
  input wire logic match_out_enable_n,
  input wire logic [cam_host_pkg::WORD_W-1:0] word_bus_in,
  output logic [cam_host_pkg::WORD_W-1:0] word_bus_out,
  output logic word_bus_oe_n,
  output logic [cam_host_pkg::INDEX_W-1:0] match_index,
  output logic match_index_oe_n,
  output logic multi_match_err_out,
  output logic multi_match_err_oe_n,
  input wire logic [cam_host_pkg::MASK_W-1:0] cascade_mask_in,
  output logic [cam_host_pkg::MASK_W-1:0] cascade_mask_out,
  output logic cascade_mask_oe_n,
  input wire logic cascade_drive,
  output logic req_valid,
  output cam_host_pkg::host_req_t req,
  output logic stalled,
  input wire logic [cam_host_pkg::WORD_W-1:0] read_word,
  input cam_host_pkg::match_res_t match_res,
  output logic [cam_host_pkg::MASK_W-1:0] cascade_mask_seen
);
  import cam_host_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [ADDR_W+WORD_W+MASK_W+7:0] sync1_reg;
  logic [ADDR_W+WORD_W+MASK_W+7:0] sync2_reg;
  wire [ADDR_W+WORD_W+MASK_W+7:0] pins_raw = {stall_n, chip_sel_n, chip_sel_b_n, space_mem,
    write_n, read_oe_n, match_out_enable_n, cascade_drive, addr_bus, word_bus_in, cascade_mask_in};

  // Two flops per pin before any logic looks at it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // ------------------------------------------------------------
  // Decoded pin levels
  // ------------------------------------------------------------
  wire s_stall_n = sync2_reg[ADDR_W+WORD_W+MASK_W+7];
  wire s_cs_n = sync2_reg[ADDR_W+WORD_W+MASK_W+6];
  wire s_cs_b_n = sync2_reg[ADDR_W+WORD_W+MASK_W+5];
  wire s_space = sync2_reg[ADDR_W+WORD_W+MASK_W+4];
  wire s_we_n = sync2_reg[ADDR_W+WORD_W+MASK_W+3];
  wire s_oe_n = sync2_reg[ADDR_W+WORD_W+MASK_W+2];
  wire s_moe_n = sync2_reg[ADDR_W+WORD_W+MASK_W+1];
  wire s_casc = sync2_reg[ADDR_W+WORD_W+MASK_W];
  wire [ADDR_W-1:0] s_addr = sync2_reg[ADDR_W+WORD_W+MASK_W-1:WORD_W+MASK_W];
  wire [WORD_W-1:0] s_data = sync2_reg[WORD_W+MASK_W-1:MASK_W];
  wire [MASK_W-1:0] s_mask = sync2_reg[MASK_W-1:0];

  wire selected = !s_cs_n && !s_cs_b_n; // [RQ5]
  wire stall_req = !s_stall_n; // [RQ2]
  wire mem_space = (s_space == SPACE_MEMORY); // [RQ12]
  // Register space keeps only the low address bits [RQ8]
  wire [ADDR_W-1:0] eff_addr = mem_space ? s_addr :
    {{(REG_IGN_HI-REG_IGN_LO+1){1'b0}}, s_addr[REG_ADDR_W-1:0]}; // [RQ7]

  // ------------------------------------------------------------
  // Stall sequencer
  // ------------------------------------------------------------
  stall_state_t state_reg;
  stall_state_t state_next;
  wire in_stall = (state_reg == STALL_ST);

  // One stall cycle after a sampled request, then back to running
  always_comb begin
    case (state_reg)
      RUN_ST: state_next = stall_req ? STALL_ST : RUN_ST; // [RQ2]
      STALL_ST: state_next = RUN_ST; // [RQ2]
      default: state_next = RUN_ST;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= RUN_ST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // Request capture toward the core
  // ------------------------------------------------------------
  host_req_t req_next;
  wire take_req = selected && !in_stall && (!s_we_n || !s_oe_n);

  always_comb begin
    req_next.write = !s_we_n; // [RQ14]
    req_next.space_mem = mem_space; // [RQ12]
    req_next.addr = eff_addr; // [RQ7] [RQ8]
    req_next.data = s_data; // [RQ9]
  end

  // Request held through a stall, pulsed valid otherwise
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req <= '0;
      req_valid <= 1'b0;
      stalled <= 1'b0;
    end else begin
      req_valid <= take_req;
      stalled <= in_stall;
      if (take_req) begin
        req <= req_next;
      end
    end
  end

  // ------------------------------------------------------------
  // Output values, frozen during a stall
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      word_bus_out <= '0;
      match_index <= '0;
      multi_match_err_out <= 1'b0;
      cascade_mask_out <= '0;
      cascade_mask_seen <= '0;
    end else if (!in_stall) begin // [RQ3]
      word_bus_out <= read_word; // [RQ9]
      match_index <= match_res.index;
      multi_match_err_out <= 1'b0; // Open drain only pulls low
      cascade_mask_out <= match_res.mask;
      cascade_mask_seen <= s_mask;
    end
  end

  // ------------------------------------------------------------
  // Output enables, live even during a stall
  // ------------------------------------------------------------
  wire word_drive = selected && !s_oe_n && s_we_n; // [RQ10] [RQ11] [RQ6] [RQ4]
  wire match_drive = selected && !s_moe_n; // [RQ13] [RQ6] [RQ4]
  wire err_drive = match_drive && match_res.multi_match; // [RQ13]
  wire casc_drive = selected && s_casc; // [RQ6] [RQ4]

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      word_bus_oe_n <= 1'b1;
      match_index_oe_n <= 1'b1;
      multi_match_err_oe_n <= 1'b1;
      cascade_mask_oe_n <= 1'b1;
    end else begin
      word_bus_oe_n <= !word_drive;
      match_index_oe_n <= !match_drive;
      multi_match_err_oe_n <= !err_drive;
      cascade_mask_oe_n <= !casc_drive;
    end
  end
endmodule : cam_host_bus_interface

// File: inc/cam_host_pkg.sv
// Package: widths, field positions, timing counts and carrier types of the host port
package cam_host_pkg;
  localparam int ADDR_W = 13;
  localparam int WORD_W = 64;
  localparam int INDEX_W = 13;
  localparam int MASK_W = 64;
  localparam int REG_ADDR_W = 8; // Low address bits decoded in register space
  localparam int REG_IGN_HI = 12; // Top ignored address bit in register space
  localparam int REG_IGN_LO = 8; // Lowest ignored address bit in register space
  localparam int CLK_HZ = 20000000;
  localparam int CLK_MAX_NORMAL_MHZ = 33;
  localparam int CLK_MAX_REGOUT_MHZ = 50;
  localparam int STALL_CYCLES_NS = 50; // One clock period of stall
  localparam int STALL_CYCLES = (STALL_CYCLES_NS * (CLK_HZ / 1000000)) / 1000;
  localparam logic SPACE_MEMORY = 1'b1;
  localparam logic SPACE_REGISTER = 1'b0;

  // Stall sequencer states
  typedef enum logic [0:0] {
    RUN_ST = 1'b0,
    STALL_ST = 1'b1
  } stall_state_t;

  // Host request captured on a clock edge
  typedef struct packed {
    logic write;
    logic space_mem;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } host_req_t;

  // Result coming back from the search core
  typedef struct packed {
    logic [INDEX_W-1:0] index;
    logic multi_match;
    logic [MASK_W-1:0] mask;
  } match_res_t;
endpackage : cam_host_pkg

// File: test/cam_host_props.sv
// Checker: select, strobe, stall and float relations at the host port
`timescale 1ns/1ps
module cam_host_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic stall_n,
  input wire logic chip_sel_n,
  input wire logic chip_sel_b_n,
  input wire logic space_mem,
  input wire logic write_n,
  input wire logic read_oe_n,
  input wire logic match_out_enable_n,
  input wire logic word_bus_oe_n,
  input wire logic match_index_oe_n,
  input wire logic cascade_mask_oe_n,
  input wire logic req_valid,
  input cam_host_pkg::host_req_t req,
  input wire logic stalled
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_unsel_float: assert property ((chip_sel_n || chip_sel_b_n)[*4] |->
    word_bus_oe_n && match_index_oe_n && cascade_mask_oe_n) else $error("unselected drive");
  chk_write_float: assert property ((!write_n)[*4] |-> word_bus_oe_n)
    else $error("bus driven in write");
  chk_read_gate: assert property (read_oe_n[*4] |-> word_bus_oe_n)
    else $error("bus driven without read");
  chk_match_float: assert property (match_out_enable_n[*4] |-> match_index_oe_n)
    else $error("index driven while off");
  chk_stall_once: assert property (stalled |=> !stalled)
    else $error("stall too long");
  chk_stall_cause: assert property ($rose(stalled) |->
    !$past(stall_n, 3) || !$past(stall_n, 4)) else $error("stall without request");
  chk_req_select: assert property (req_valid |->
    !$past(chip_sel_n, 3) && !$past(chip_sel_b_n, 3)) else $error("request unselected");
  chk_reg_addr: assert property (req_valid && !req.space_mem |->
    req.addr[12:8] == 5'h00) else $error("register address high bits kept");
  chk_space_follow: assert property (req_valid |->
    req.space_mem == $past(space_mem, 3)) else $error("space select lost");
  cover property (req_valid && req.write);
  cover property (stalled);
  cover property (!word_bus_oe_n);
endmodule : cam_host_props
bind cam_host_bus_interface cam_host_props chk (.clk_sys, .rst, .stall_n, .chip_sel_n,
  .chip_sel_b_n, .space_mem, .write_n, .read_oe_n, .match_out_enable_n, .word_bus_oe_n,
  .match_index_oe_n, .cascade_mask_oe_n, .req_valid, .req, .stalled);

// File: test/host_pin_model.sv
// Host model: drives select and strobes, resolves the shared buses
`timescale 1ns/1ps
module host_pin_model (
  input wire logic clk_sys,
  input wire logic [63:0] dev_word,
  input wire logic dev_oe_n,
  input wire logic [63:0] dev_mask,
  input wire logic mask_oe_n,
  output logic [63:0] bus_word,
  output logic [63:0] bus_mask,
  output logic [4:0] ctl,
  output logic [12:0] addr
);
  logic [63:0] wdata = 64'h0;
  logic [63:0] last = 64'h0;
  // Released data line shows the inverse of its last level
  always_ff @(posedge clk_sys) last <= bus_word;
  assign bus_word = !dev_oe_n ? dev_word : !ctl[1] ? wdata : ~last;
  assign bus_mask = !mask_oe_n ? dev_mask : 64'hffff_ffff_ffff_ffff; // Pull-up
  initial {ctl, addr} = {5'h1b, 13'h0000};
  // Pins {cs, cs_b, space, write, read} change after the edge and hold
  task automatic put(input logic [4:0] c, input logic [12:0] a, input logic [63:0] d);
    @(posedge clk_sys);
    ctl <= c;
    addr <= a;
    wdata <= d;
  endtask : put
endmodule : host_pin_model

// File: test/cam_host_bus_interface_bench.sv
// Bench: scenario tasks for the host port
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module cam_host_bus_interface_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic stall_n = 1'b1;
  logic moe_n = 1'b1;
  logic cdrive = 1'b0;
  logic [63:0] rword = 64'h0123_4567_89ab_cdef;
  cam_host_pkg::match_res_t mres = '0;
  cam_host_pkg::host_req_t req;
  logic [63:0] wb_in, wb_out, cm_in, cm_out, cseen;
  logic [12:0] addr, mindex;
  logic [4:0] ctl;
  logic woe_n, mioe_n, eoe_n, cmoe_n, valid, stalled, eout;
  int num_errors = 0;
  int checked = 0;
  int n;
  host_pin_model host (.clk_sys(clk_sys), .dev_word(wb_out), .dev_oe_n(woe_n),
    .dev_mask(cm_out), .mask_oe_n(cmoe_n), .bus_word(wb_in), .bus_mask(cm_in),
    .ctl(ctl), .addr(addr));
  cam_host_bus_interface dut (.clk_sys(clk_sys), .rst(rst), .stall_n(stall_n),
    .chip_sel_n(ctl[4]), .chip_sel_b_n(ctl[3]), .addr_bus(addr), .space_mem(ctl[2]),
    .write_n(ctl[1]), .read_oe_n(ctl[0]), .match_out_enable_n(moe_n), .word_bus_in(wb_in),
    .word_bus_out(wb_out), .word_bus_oe_n(woe_n), .match_index(mindex),
    .match_index_oe_n(mioe_n), .multi_match_err_out(eout), .multi_match_err_oe_n(eoe_n),
    .cascade_mask_in(cm_in), .cascade_mask_out(cm_out), .cascade_mask_oe_n(cmoe_n),
    .cascade_drive(cdrive), .req_valid(valid), .req(req), .stalled(stalled),
    .read_word(rword), .match_res(mres), .cascade_mask_seen(cseen));
  // 20 MHz clock, well under the host limit
  initial forever #25 clk_sys = ~clk_sys;
  task automatic final_report;
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // Count request pulses or stall cycles over a span
  task automatic count(input int span, input logic stl);
    n = 0;
    repeat (span) begin
      @(posedge clk_sys); #1;
      n += stl ? int'(stalled === 1'b1) : int'(valid === 1'b1);
    end
  endtask : count
  task automatic write_mem;
    host.put(5'h05, 13'h1abc, 64'hdead_beef_0bad_f00d);
    count(5, 1'b0);
    `CHK(req, {2'b11, 13'h1abc, 64'hdead_beef_0bad_f00d})
    `CHK(woe_n, 1'b1)
  endtask : write_mem
  task automatic read_reg_stall;
    host.put(5'h02, 13'h1fa5, 64'h0);
    count(5, 1'b0);
    `CHK({req.write, req.space_mem, req.addr}, {2'b00, 13'h00a5})
    `CHK(wb_in, rword)
    @(posedge clk_sys);
    stall_n <= 1'b0;
    @(posedge clk_sys);
    stall_n <= 1'b1;
    count(8, 1'b1);
    `CHK(n, 1)
    `CHK(woe_n, 1'b0)
  endtask : read_reg_stall
  task automatic one_select;
    host.put(5'h0d, 13'h0011, 64'h5a5a_5a5a_5a5a_5a5a);
    // Let the read pulses already in the synchronisers drain
    repeat (3) @(posedge clk_sys);
    count(6, 1'b0);
    `CHK(n, 0)
    `CHK({woe_n, mioe_n, eoe_n, cmoe_n}, 4'hf)
  endtask : one_select
  task automatic match_out;
    host.put(5'h03, 13'h0000, 64'h0);
    moe_n <= 1'b0;
    mres <= {13'h0abc, 1'b1, 64'h0f0f_0000_ffff_1234};
    cdrive <= 1'b1;
    count(5, 1'b0);
    `CHK({mioe_n, eoe_n, mindex}, {2'b00, 13'h0abc})
    `CHK(eout, 1'b0)
    `CHK({cmoe_n, cm_in}, {1'b0, 64'h0f0f_0000_ffff_1234})
    @(posedge clk_sys);
    moe_n <= 1'b1;
    count(5, 1'b0);
    `CHK({mioe_n, eoe_n}, 2'b11)
    `CHK(cseen, 64'h0f0f_0000_ffff_1234)
  endtask : match_out
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    write_mem();
    read_reg_stall();
    one_select();
    match_out();
    final_report();
  end
  // Watchdog well past the expected run
  initial begin
    repeat (2000) @(posedge clk_sys);
    num_errors++;
    final_report();
  end
endmodule : cam_host_bus_interface_bench
